/* wrc_cfg.svh */
`ifndef WRC_CFG_SVH
`define WRC_CFG_SVH

// Clock rate and the 2 kHz bit clock of the load modulator.
`define WRC_CLK_MHZ 250
`define WRC_BIT_CLK_KHZ 2
`define WRC_BIT_CYC (`WRC_CLK_MHZ * 1000 / `WRC_BIT_CLK_KHZ)
`define WRC_BITCNT_W 17

// Target address on the two-wire port.
`define WRC_I2C_ADDR 7'h22

// Register offsets.
`define WRC_REG_FREQ_LO 8'h02
`define WRC_REG_FREQ_HI 8'h03
`define WRC_REG_OUT_EN 8'h10
`define WRC_REG_LVL0 8'h20
`define WRC_REG_TH0 8'h24
`define WRC_REG_HOST_CMD 8'h30
`define WRC_REG_VRECT 8'h64
`define WRC_REG_VOUT 8'h66
`define WRC_REG_OUTPUT_CURRENT_READING 8'h67
`define WRC_REG_LAST_CE 8'h78
`define WRC_REG_LAST_RP 8'h79
`define WRC_REG_PWR_LO 8'h7a
`define WRC_REG_PWR_HI 8'h7b
`define WRC_REG_PHASE 8'h7c

// Field positions.
`define WRC_OUT_EN_BIT 7
`define WRC_HOST_CC_BIT 0
`define WRC_HOST_BF_BIT 1

// Reset values of the programmable levels and load current thresholds.
`define WRC_LVL0_RST 8'hc0
`define WRC_LVL1_RST 8'hb0
`define WRC_LVL2_RST 8'ha0
`define WRC_LVL3_RST 8'h90
`define WRC_TH0_RST 8'h20
`define WRC_TH1_RST 8'h40
`define WRC_TH2_RST 8'h80

// Thermistor codes, each VTS/2*1024.
`define WRC_TS_HOT 10'h08e
`define WRC_TS_COLD 10'h3a4
`define WRC_TS_REG 10'h192
`define WRC_TS_LOW 10'h000
`define WRC_TS_HIGH 10'h3ff

// Terminate packet header and reason codes.
`define WRC_EPT_HDR 8'h02
`define WRC_EPT_UNKNOWN 8'h00
`define WRC_EPT_CHG_DONE 8'h01
`define WRC_EPT_INT_FAULT 8'h02
`define WRC_EPT_OVER_TEMP 8'h03
`define WRC_EPT_BATT_FAIL 8'h06
`define WRC_EPT_NO_RESP 8'h08

// Synchronised pin positions.
`define WRC_PIN_SCL 0
`define WRC_PIN_SDA 1
`define WRC_PIN_M0 2
`define WRC_PIN_M1 3
`define WRC_PIN_ADP 4
`define WRC_PIN_TJ 5

`endif

/* wrc_pkg.sv */
package wrc_pkg;

  // Operating mode as {high mode pin, low mode pin}.
  typedef enum logic [1:0] {
    WRC_MODE_DEFAULT = 2'b00,
    WRC_MODE_ADAPTER = 2'b01,
    WRC_MODE_WIRELESS = 2'b10,
    WRC_MODE_DISABLE = 2'b11
  } wrc_mode_t;

  // Two-wire target states.
  typedef enum logic [3:0] {
    WRC_I_IDLE = 4'h0,
    WRC_I_ADDR = 4'h1,
    WRC_I_ACK_A = 4'h2,
    WRC_I_REG = 4'h3,
    WRC_I_ACK_R = 4'h4,
    WRC_I_WR = 4'h5,
    WRC_I_ACK_W = 4'h6,
    WRC_I_RD = 4'h7,
    WRC_I_ACK_M = 4'h8
  } wrc_i2c_st_t;

  // Measurements and status delivered by the converter logic.
  typedef struct packed {
    logic [7:0] vrect;
    logic [7:0] vout;
    logic [7:0] output_current_reading;
    logic [9:0] ts;
    logic [13:0] freq;
    logic [7:0] last_ce;
    logic [7:0] last_rp;
    logic [14:0] pwr;
    logic pwr_upd;
    logic [3:0] phase;
  } wrc_meas_t;

  // Complete state of the control block.
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0] pf;
    wrc_i2c_st_t ist;
    logic [7:0] sh;
    logic [3:0] bc;
    logic [7:0] ptr;
    logic rw;
    logic mack;
    logic oe;
    logic [3:0][7:0] lvl;
    logic [2:0][7:0] th;
    logic out_en;
    logic host_cc;
    logic host_bf;
    logic [1:0] idx;
    logic [7:0] rect;
    logic [1:0] ept_stage;
    logic ept_done;
    logic [7:0] reason;
    logic [16:0] bcyc;
    logic [10:0] tsh;
    logic [3:0] tleft;
    logic cur_act;
    logic cur_one;
    logic mod;
    logic wl;
    logic adp_n;
    logic otg;
    logic ilim_red;
  } wrc_state_t;

endpackage : wrc_pkg

/* wrc_top.sv */
`timescale 1ns/1ps
`include "wrc_cfg.svh"

// Byte buffer between packet sources and the load modulator.
module wrc_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Filling side.
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Draining side.
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);

  // All buffer state; depth must be a power of two so pointers wrap.
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] cnt;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
  } wrc_fifo_t;

  wrc_fifo_t f_r;
  wrc_fifo_t f_nxt;
  logic wr_en;
  logic rd_en;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (f_r.cnt != (AW + 1)'(D));
  assign out_valid = (f_r.cnt != '0);
  assign out_data = f_r.mem[f_r.rp];
  assign wr_en = in_valid && in_ready;
  assign rd_en = out_valid && out_ready;

  // Next state of pointers, count and storage.
  always_comb
  begin
    f_nxt = f_r;
    if (wr_en)
    begin
      f_nxt.mem[f_r.wp] = in_data;
      f_nxt.wp = f_r.wp + 1'b1;
    end
    if (rd_en)
    begin
      f_nxt.rp = f_r.rp + 1'b1;
    end
    f_nxt.cnt = f_r.cnt + (AW + 1)'(wr_en) - (AW + 1)'(rd_en);
  end

  // State register.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      f_r <= '0;
    end
    else
    begin
      f_r <= f_nxt;
    end
  end
endmodule : wrc_fifo

// Control and communication logic of the inductive power receiver.
module wrc_top #(
  parameter int BIT_CYC = `WRC_BIT_CYC
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Two-wire target pins.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Mode pins, adapter detect and junction over-temperature.
  input wire logic mode_select_low_bit,
  input wire logic mode_select_high_bit,
  input wire logic adapter_detect,
  input wire logic junction_hot,
  // Converter measurements and loop status.
  input wire wrc_pkg::wrc_meas_t meas,
  input wire logic rect_not_converged,
  // Packet bytes from the packet builder.
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready,
  // Load modulation switches.
  output logic comm_switch_a,
  output logic comm_switch_b,
  // Power path control.
  output logic wireless_enable,
  output logic adapter_switch_drive_n,
  output logic otg_allow,
  output logic output_enable,
  output logic current_limit_reduced,
  output logic [7:0] rect_target_level_n
);

  wrc_pkg::wrc_state_t st_r;
  wrc_pkg::wrc_state_t nx;
  logic [5:0] pins;
  logic [5:0] pf_n;
  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;
  logic i2c_ok;
  logic [7:0] rd_byte;
  logic ts_over;
  logic ts_high;
  logic ept_cond;
  logic ept_go;
  logic [7:0] ept_reason;
  logic fifo_in_valid;
  logic [7:0] fifo_in_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_out_ready;
  logic rise_tick;
  logic half_tick;
  logic [7:0] lvl_sel;
  wrc_pkg::wrc_mode_t mode;

  // Lower edge of a band when current falls: threshold less about 5 percent.
  function automatic logic [7:0] hyst_lo(input logic [7:0] th);
    logic [15:0] prod;
    prod = 16'(th) * 16'h000d;
    return th - prod[15:8];
  endfunction : hyst_lo

  // Byte frame sent LSB first: start zero, data, odd parity, stop one.
  function automatic logic [10:0] frame(input logic [7:0] b);
    return {1'b1, ~^b, b, 1'b0};
  endfunction : frame

  assign pins = {junction_hot, adapter_detect, mode_select_high_bit,
                 mode_select_low_bit, sda_i, scl_i};

  // A pin changes only once the second and third stages agree.
  assign pf_n = ((st_r.s2 ^ st_r.s3) & st_r.pf) | (~(st_r.s2 ^ st_r.s3) & st_r.s3);
  assign scl_rise = pf_n[`WRC_PIN_SCL] && !st_r.pf[`WRC_PIN_SCL];
  assign scl_fall = !pf_n[`WRC_PIN_SCL] && st_r.pf[`WRC_PIN_SCL];
  assign i2c_start = st_r.pf[`WRC_PIN_SCL] && pf_n[`WRC_PIN_SCL]
                     && st_r.pf[`WRC_PIN_SDA] && !pf_n[`WRC_PIN_SDA];
  assign i2c_stop = st_r.pf[`WRC_PIN_SCL] && pf_n[`WRC_PIN_SCL]
                    && !st_r.pf[`WRC_PIN_SDA] && pf_n[`WRC_PIN_SDA];
  assign mode = wrc_pkg::wrc_mode_t'({st_r.pf[`WRC_PIN_M1], st_r.pf[`WRC_PIN_M0]});

  // The port answers only while wireless operation runs.
  assign i2c_ok = st_r.wl;

  // Thermistor windows on the 10-bit code scale.
  assign ts_high = (meas.ts == `WRC_TS_HIGH);
  assign ts_over = !ts_high && ((meas.ts < `WRC_TS_HOT) || (meas.ts > `WRC_TS_COLD)
                   || (meas.ts == `WRC_TS_LOW));

  // Reason selection; over-voltage, over-current and reconfigure never occur.
  always_comb
  begin
    ept_cond = 1'b1;
    if (st_r.pf[`WRC_PIN_TJ])
      ept_reason = `WRC_EPT_INT_FAULT;
    else if (ts_over)
      ept_reason = `WRC_EPT_OVER_TEMP;
    else if (st_r.host_cc || st_r.pf[`WRC_PIN_M0] || ts_high)
      ept_reason = `WRC_EPT_CHG_DONE;
    else if (st_r.host_bf)
      ept_reason = `WRC_EPT_BATT_FAIL;
    else if (rect_not_converged)
      ept_reason = `WRC_EPT_NO_RESP;
    else if (st_r.pf[`WRC_PIN_ADP])
      ept_reason = `WRC_EPT_UNKNOWN;
    else
    begin
      ept_reason = `WRC_EPT_UNKNOWN;
      ept_cond = 1'b0;
    end
  end

  // One request per onset of a condition, only while wireless power is on.
  assign ept_go = ept_cond && st_r.wl && !st_r.ept_done && (st_r.ept_stage == 2'd0);

  // Read data for the current pointer.
  always_comb
  begin
    case (st_r.ptr)
      `WRC_REG_FREQ_LO: rd_byte = meas.freq[7:0];
      `WRC_REG_FREQ_HI: rd_byte = {2'h0, meas.freq[13:8]};
      `WRC_REG_OUT_EN: rd_byte = {st_r.out_en, 7'h00};
      `WRC_REG_VRECT: rd_byte = meas.vrect;
      `WRC_REG_VOUT: rd_byte = meas.vout;
      `WRC_REG_OUTPUT_CURRENT_READING: rd_byte = meas.output_current_reading;
      `WRC_REG_LAST_CE: rd_byte = meas.last_ce;
      `WRC_REG_LAST_RP: rd_byte = meas.last_rp;
      `WRC_REG_PWR_LO: rd_byte = meas.pwr[7:0];
      `WRC_REG_PWR_HI: rd_byte = {meas.pwr_upd, meas.pwr[14:8]};
      `WRC_REG_PHASE: rd_byte = {4'h0, meas.phase};
      `WRC_REG_HOST_CMD: rd_byte = {6'h00, st_r.host_bf, st_r.host_cc};
      default:
      begin
        if (st_r.ptr >= `WRC_REG_LVL0 && st_r.ptr < `WRC_REG_TH0)
          rd_byte = st_r.lvl[st_r.ptr[1:0]];
        else if (st_r.ptr >= `WRC_REG_TH0 && st_r.ptr < `WRC_REG_TH0 + 8'h03)
          rd_byte = st_r.th[st_r.ptr[1:0]];
        else
          rd_byte = 8'h00;
      end
    endcase
  end

  // Terminate packets take the buffer ahead of the packet builder.
  assign fifo_in_valid = (st_r.ept_stage != 2'd0) || tx_valid;
  assign fifo_in_data = (st_r.ept_stage == 2'd1) ? `WRC_EPT_HDR :
                        (st_r.ept_stage == 2'd2) ? st_r.reason : tx_byte;
  assign tx_ready = fifo_in_ready && (st_r.ept_stage == 2'd0);
  assign fifo_out_ready = (st_r.tleft == 4'h0);

  // Bit clock phases: rising edge at count zero, falling edge halfway.
  assign rise_tick = (st_r.bcyc == '0);
  assign half_tick = (st_r.bcyc == `WRC_BITCNT_W'(BIT_CYC / 2));
  assign lvl_sel = st_r.lvl[st_r.idx];

  wrc_fifo #(
    .W(8),
    .D(16)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .in_valid(fifo_in_valid),
    .in_data(fifo_in_data),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_out_ready)
  );

  // Next state of the whole block.
  always_comb
  begin
    nx = st_r;
    nx.s1 = pins;
    nx.s2 = st_r.s1;
    nx.s3 = st_r.s2;
    nx.pf = pf_n;

    // Two-wire target; a start or stop restarts it from any state.
    if (i2c_stop || (i2c_start && !i2c_ok))
    begin
      nx.ist = wrc_pkg::WRC_I_IDLE;
      nx.oe = 1'b0;
    end
    else if (i2c_start)
    begin
      nx.ist = wrc_pkg::WRC_I_ADDR;
      nx.bc = 4'h0;
      nx.oe = 1'b0;
    end
    else if (scl_rise)
    begin
      if (st_r.ist == wrc_pkg::WRC_I_ACK_M)
        nx.mack = !st_r.pf[`WRC_PIN_SDA];
      else if (st_r.ist == wrc_pkg::WRC_I_ADDR || st_r.ist == wrc_pkg::WRC_I_REG
               || st_r.ist == wrc_pkg::WRC_I_WR)
      begin
        nx.sh = {st_r.sh[6:0], st_r.pf[`WRC_PIN_SDA]};
        nx.bc = st_r.bc + 4'h1;
      end
      else if (st_r.ist == wrc_pkg::WRC_I_RD)
        nx.bc = st_r.bc + 4'h1;
    end
    else if (scl_fall)
    begin
      case (st_r.ist)
        wrc_pkg::WRC_I_ADDR:
        begin
          if (st_r.bc == 4'h8)
          begin
            if (st_r.sh[7:1] == `WRC_I2C_ADDR)
            begin
              nx.ist = wrc_pkg::WRC_I_ACK_A;
              nx.rw = st_r.sh[0];
              nx.oe = 1'b1;
            end
            else
              nx.ist = wrc_pkg::WRC_I_IDLE;
          end
        end
        wrc_pkg::WRC_I_ACK_A, wrc_pkg::WRC_I_ACK_M:
        begin
          if ((st_r.ist == wrc_pkg::WRC_I_ACK_A && st_r.rw) ||
              (st_r.ist == wrc_pkg::WRC_I_ACK_M && st_r.mack))
          begin
            nx.ist = wrc_pkg::WRC_I_RD;
            nx.sh = rd_byte;
            nx.oe = !rd_byte[7];
            nx.ptr = st_r.ptr + 8'h01;
          end
          else
          begin
            nx.ist = (st_r.ist == wrc_pkg::WRC_I_ACK_A) ? wrc_pkg::WRC_I_REG
                                                       : wrc_pkg::WRC_I_IDLE;
            nx.oe = 1'b0;
          end
          nx.bc = 4'h0;
        end
        wrc_pkg::WRC_I_REG:
        begin
          if (st_r.bc == 4'h8)
          begin
            nx.ptr = st_r.sh;
            nx.ist = wrc_pkg::WRC_I_ACK_R;
            nx.oe = 1'b1;
          end
        end
        wrc_pkg::WRC_I_WR:
        begin
          if (st_r.bc == 4'h8)
          begin
            // Register writes; the pointer steps after each byte.
            if (st_r.ptr == `WRC_REG_OUT_EN)
              nx.out_en = st_r.sh[`WRC_OUT_EN_BIT];
            else if (st_r.ptr >= `WRC_REG_LVL0 && st_r.ptr < `WRC_REG_TH0)
              nx.lvl[st_r.ptr[1:0]] = st_r.sh;
            else if (st_r.ptr >= `WRC_REG_TH0 && st_r.ptr < `WRC_REG_TH0 + 8'h03)
              nx.th[st_r.ptr[1:0]] = st_r.sh;
            nx.ptr = st_r.ptr + 8'h01;
            nx.ist = wrc_pkg::WRC_I_ACK_W;
            nx.oe = 1'b1;
          end
        end
        wrc_pkg::WRC_I_ACK_R, wrc_pkg::WRC_I_ACK_W:
        begin
          nx.ist = wrc_pkg::WRC_I_WR;
          nx.bc = 4'h0;
          nx.oe = 1'b0;
        end
        wrc_pkg::WRC_I_RD:
        begin
          // Release the line for the master's acknowledge after eight bits.
          if (st_r.bc == 4'h8)
          begin
            nx.ist = wrc_pkg::WRC_I_ACK_M;
            nx.oe = 1'b0;
          end
          else
          begin
            nx.sh = {st_r.sh[6:0], 1'b0};
            nx.oe = !st_r.sh[6];
          end
        end
        default: nx.ist = st_r.ist;
      endcase
    end

    // Host command bits clear when their packet is queued; a new write wins.
    if (st_r.ept_stage == 2'd2 && fifo_in_ready)
    begin
      if (st_r.reason == `WRC_EPT_CHG_DONE)
        nx.host_cc = 1'b0;
      if (st_r.reason == `WRC_EPT_BATT_FAIL)
        nx.host_bf = 1'b0;
    end
    if (scl_fall && st_r.ist == wrc_pkg::WRC_I_WR && st_r.bc == 4'h8
        && st_r.ptr == `WRC_REG_HOST_CMD)
    begin
      nx.host_cc = st_r.host_cc | st_r.sh[`WRC_HOST_CC_BIT];
      nx.host_bf = st_r.host_bf | st_r.sh[`WRC_HOST_BF_BIT];
    end

    // Load current bands: step up above a threshold, down below its lower edge.
    if (st_r.idx != 2'd3 && meas.output_current_reading > st_r.th[st_r.idx])
      nx.idx = st_r.idx + 2'd1;
    else if (st_r.idx != 2'd0 && meas.output_current_reading < hyst_lo(st_r.th[st_r.idx - 2'd1]))
      nx.idx = st_r.idx - 2'd1;
    nx.rect = lvl_sel;

    // Temperature regulation: the code falls as the thermistor heats.
    nx.ilim_red = (meas.ts <= `WRC_TS_REG);

    // Terminate request: latch reason, then queue header and reason bytes.
    if (!ept_cond)
      nx.ept_done = 1'b0;
    if (ept_go)
    begin
      nx.ept_stage = 2'd1;
      nx.reason = ept_reason;
    end
    else if (st_r.ept_stage != 2'd0 && fifo_in_ready)
    begin
      nx.ept_stage = (st_r.ept_stage == 2'd1) ? 2'd2 : 2'd0;
      nx.ept_done = (st_r.ept_stage == 2'd2);
    end

    // Bit clock counter runs free so bit edges stay on the 2 kHz grid.
    nx.bcyc = (st_r.bcyc == `WRC_BITCNT_W'(BIT_CYC - 1)) ? '0 : st_r.bcyc + 1'b1;

    // Differential bi-phase modulator.
    if (fifo_out_valid && st_r.tleft == 4'h0)
    begin
      nx.tsh = frame(fifo_out_data);
      nx.tleft = 4'd11;
    end
    if (rise_tick)
    begin
      if (st_r.tleft != 4'h0)
      begin
        nx.mod = !st_r.mod;
        nx.cur_one = st_r.tsh[0];
        nx.cur_act = 1'b1;
        nx.tsh = {1'b0, st_r.tsh[10:1]};
        nx.tleft = st_r.tleft - 4'h1;
      end
      else
      begin
        nx.mod = 1'b0;
        nx.cur_act = 1'b0;
      end
    end
    else if (half_tick && st_r.cur_act && st_r.cur_one)
      nx.mod = !st_r.mod;

    // Mode decode; the adapter wins in default mode.
    case (mode)
      wrc_pkg::WRC_MODE_DEFAULT:
      begin
        nx.wl = !st_r.pf[`WRC_PIN_ADP];
        nx.adp_n = !st_r.pf[`WRC_PIN_ADP];
        nx.otg = 1'b0;
      end
      wrc_pkg::WRC_MODE_WIRELESS:
      begin
        nx.wl = 1'b1;
        nx.adp_n = 1'b1;
        nx.otg = 1'b0;
      end
      wrc_pkg::WRC_MODE_ADAPTER:
      begin
        nx.wl = 1'b0;
        nx.adp_n = 1'b0;
        nx.otg = 1'b1;
      end
      default:
      begin
        nx.wl = 1'b0;
        nx.adp_n = 1'b1;
        nx.otg = 1'b0;
      end
    endcase
  end

  // State register; the bus pins idle high, so their filtered lines start high.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= '0;
      // Every stage starts at the idle level of the bus pins, so no false edge follows reset.
      st_r.s1 <= 6'h03;
      st_r.s2 <= 6'h03;
      st_r.s3 <= 6'h03;
      st_r.pf <= 6'h03;
      st_r.adp_n <= 1'b1;
      st_r.lvl <= {`WRC_LVL3_RST, `WRC_LVL2_RST, `WRC_LVL1_RST, `WRC_LVL0_RST};
      st_r.th <= {`WRC_TH2_RST, `WRC_TH1_RST, `WRC_TH0_RST};
      st_r.rect <= `WRC_LVL0_RST;
    end
    else
    begin
      st_r <= nx;
    end
  end

  // Outputs; both switches follow one modulation state.
  assign comm_switch_a = st_r.mod;
  assign comm_switch_b = st_r.mod;
  assign sda_o = 1'b0;
  assign sda_oe = st_r.oe;
  assign wireless_enable = st_r.wl;
  assign adapter_switch_drive_n = st_r.adp_n;
  assign otg_allow = st_r.otg;
  assign output_enable = st_r.out_en && st_r.wl;
  assign current_limit_reduced = st_r.ilim_red;
  assign rect_target_level_n = st_r.rect;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_rect_sel;
    1'b1 |=> rect_target_level_n == $past(lvl_sel);
  endproperty
  a_rect_sel: assert property (p_rect_sel) else $error("rect target wrong");

  property p_hyst;
    st_r.idx == 2'd1 && meas.output_current_reading >= hyst_lo(st_r.th[0]) && meas.output_current_reading <= st_r.th[1]
      |=> st_r.idx == 2'd1;
  endproperty
  a_hyst: assert property (p_hyst) else $error("band left inside hysteresis");

  property p_ept_temp;
    ept_go && ts_over && !st_r.pf[`WRC_PIN_TJ]
      |=> st_r.ept_stage == 2'd1 && st_r.reason == `WRC_EPT_OVER_TEMP;
  endproperty
  a_ept_temp: assert property (p_ept_temp) else $error("no over temp request");

  property p_ilim;
    meas.ts <= `WRC_TS_REG |=> current_limit_reduced;
  endproperty
  a_ilim: assert property (p_ilim) else $error("limit not reduced");

  property p_same;
    comm_switch_a == comm_switch_b;
  endproperty
  a_same: assert property (p_same) else $error("switches differ");

  property p_one_mid;
    half_tick && st_r.cur_act && st_r.cur_one && !rise_tick
      |=> comm_switch_a != $past(comm_switch_a);
  endproperty
  a_one_mid: assert property (p_one_mid) else $error("one bit lacks mid toggle");

  property p_zero_mid;
    half_tick && st_r.cur_act && !st_r.cur_one && !rise_tick |=> $stable(comm_switch_a);
  endproperty
  a_zero_mid: assert property (p_zero_mid) else $error("zero bit toggled mid");

  property p_hdr;
    st_r.ept_stage == 2'd1 && fifo_in_ready |-> fifo_in_data == `WRC_EPT_HDR ##1
      st_r.ept_stage == 2'd2;
  endproperty
  a_hdr: assert property (p_hdr) else $error("header byte wrong");

  property p_adapter_wins;
    mode == wrc_pkg::WRC_MODE_DEFAULT && st_r.pf[`WRC_PIN_ADP]
      |=> !wireless_enable && !adapter_switch_drive_n;
  endproperty
  a_adapter_wins: assert property (p_adapter_wins) else $error("adapter not prioritised");

  property p_disable;
    mode == wrc_pkg::WRC_MODE_DISABLE |=> !wireless_enable && adapter_switch_drive_n;
  endproperty
  a_disable: assert property (p_disable) else $error("disable mode not off");

  c_ept: cover property (st_r.ept_stage == 2'd2 && fifo_in_ready);
  c_read: cover property (st_r.ist == wrc_pkg::WRC_I_ACK_M && scl_fall && st_r.mack);
  c_one_bit: cover property (half_tick && st_r.cur_act && st_r.cur_one);
  c_adapter: cover property (mode == wrc_pkg::WRC_MODE_ADAPTER);

endmodule : wrc_top

/* wrc_tx_partner.sv */
`timescale 1ns/1ps
// Transmitter model: counts switch transitions per bit and rebuilds framed bytes.
module wrc_tx_partner #(
  parameter int BIT_CYC = 40
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Load modulation seen in the coil current.
  input wire logic comm_switch_a,
  // Rebuilt bytes.
  output logic rx_stb,
  output logic [7:0] rx_byte
);
  int cnt, tog, nb; // Bit phase, transitions in the window, bits in the frame.
  logic prev; // Switch level one cycle ago.
  logic [10:0] fr; // Frame shift register; the first bit ends at the bottom.
  // The window closes a quarter bit before a rise, so both transitions of a bit land in it.
  // The model never keys its own power signal, so it never disturbs packets.
  always @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      cnt = 0;
      tog = 0;
      nb = 0;
      prev = 1'b0;
      rx_stb <= 1'b0;
      rx_byte <= 8'h00;
    end
    else
    begin
      rx_stb <= 1'b0;
      tog = tog + (comm_switch_a !== prev);
      prev = comm_switch_a;
      cnt = (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
      if (cnt == BIT_CYC - BIT_CYC / 4)
      begin
        // A silent window is idle and drops a partial frame.
        nb = (tog == 0) ? 0 : nb + 1;
        fr = {tog == 2, fr[10:1]};
        tog = 0;
        if (nb == 11)
        begin
          nb = 0;
          rx_stb <= !fr[0] && fr[10] && ^fr[9:1];
          rx_byte <= fr[8:1];
        end
      end
    end
endmodule : wrc_tx_partner

/* wrc_tb.sv */
`timescale 1ns/1ps
// Bench: two-wire host, pin and byte drivers; the partner rebuilds what is sent.
module tb;
  localparam int BC = 40; // Short bit period keeps the run brief.
  localparam int Q = 12; // One third of a two-wire bit, in clock cycles.
  logic ref_clk, rstn, scl, sda_m, tx_valid, ak;
  logic [4:0] pin; // Mode low, mode high, adapter, junction hot, not converged.
  logic [7:0] tx_byte, r, rb, q[$];
  wire sda_oe, tx_ready, csa, csb, wl, adn, otg, oen, ilim, stb;
  wire [7:0] rect, rxb;
  wire sda = sda_m & ~sda_oe; // Open drain: the device only pulls low.
  wrc_pkg::wrc_meas_t meas;
  int errors, tests_run, n, i;
  logic [7:0] iv[6] = '{8'h10, 8'h30, 8'h60, 8'ha0, 8'h7c, 8'h70};
  logic [7:0] ev[6] = '{8'hc0, 8'hb0, 8'ha0, 8'h90, 8'h90, 8'ha0};
  logic [7:0] rs[5] = '{8'h02, 8'h03, 8'h01, 8'h06, 8'h08};
  logic [7:0] me[5] = '{8'h06, 8'h01, 8'h06, 8'h02, 8'h00};
  wrc_top #(.BIT_CYC(BC)) wrc_top_inst (.ref_clk(ref_clk), .rstn(rstn), .scl_i(scl),
    .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .mode_select_low_bit(pin[0]),
    .mode_select_high_bit(pin[1]), .adapter_detect(pin[2]), .junction_hot(pin[3]),
    .meas(meas), .rect_not_converged(pin[4]), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready), .comm_switch_a(csa), .comm_switch_b(csb), .wireless_enable(wl),
    .adapter_switch_drive_n(adn), .otg_allow(otg), .output_enable(oen),
    .current_limit_reduced(ilim), .rect_target_level_n(rect));
  wrc_tx_partner #(.BIT_CYC(BC)) wrc_tx_partner_inst (.ref_clk(ref_clk), .rstn(rstn),
    .comm_switch_a(csa), .rx_stb(stb), .rx_byte(rxb));
  // Clock at 250 MHz.
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Collects bytes rebuilt by the transmitter model.
  always @(posedge ref_clk) if (stb === 1'b1) q.push_back(rxb);
  task automatic w(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : w
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : cmp8
  task automatic cmp1(input logic g, input logic e);
    cmp8({7'h00, g}, {7'h00, e});
  endtask : cmp1
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  // One two-wire bit; the line is sampled while the clock is high.
  task automatic ib(input logic b, output logic s);
    sda_m = b;
    w(Q);
    scl = 1'b1;
    w(Q);
    s = sda;
    scl = 1'b0;
    w(Q);
  endtask : ib
  // A byte, MSB first, then the acknowledge slot; a low there is an acknowledge.
  task automatic ibyte(input logic [7:0] d, output logic [7:0] g, output logic a);
    for (int k = 7; k >= 0; k--) ib(d[k], g[k]);
    ib(1'b1, a);
  endtask : ibyte
  // Start when p is high, stop when low.
  task automatic ist(input logic p);
    sda_m = p;
    w(Q);
    scl = 1'b1;
    w(Q);
    sda_m = !p;
    w(Q);
    if (p) scl = 1'b0;
    w(Q);
  endtask : ist
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ist(1'b1);
    ibyte(8'h44, rb, ak);
    cmp1(ak, 1'b0);
    ibyte(a, rb, ak);
    ibyte(d, rb, ak);
    ist(1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    ist(1'b1);
    ibyte(8'h44, rb, ak);
    ibyte(a, rb, ak);
    ist(1'b1);
    ibyte(8'h45, rb, ak);
    ibyte(8'hff, rb, ak);
    ist(1'b0);
    cmp8(rb, e);
  endtask : rd
  // Waits a bounded time for a rebuilt byte.
  task automatic getb(output logic [7:0] b);
    for (int k = 0; k < 2000 && q.size() == 0; k++) w(1);
    if (q.size() == 0)
    begin
      errors++;
      $display("wrong value at %0t: no byte arrived", $time);
      end_sim;
    end
    else b = q.pop_front();
  endtask : getb
  initial
  begin
    rstn = 1'b0;
    scl = 1'b1;
    sda_m = 1'b1;
    pin = 5'h00;
    tx_valid = 1'b0;
    tx_byte = 8'h00;
    meas = '0;
    meas.ts = 10'h200;
    errors = 0;
    tests_run = 0;
    w(6);
    rstn = 1'b1;
    w(12);
    // Up through the bands, then down inside and past the hysteresis gap.
    foreach (iv[k])
    begin
      meas.output_current_reading = iv[k];
      w(10);
      cmp8(rect, ev[k]);
    end
    meas.ts = 10'h192;
    w(8);
    cmp1(ilim, 1'b1);
    meas.ts = 10'h193;
    w(8);
    cmp1(ilim, 1'b0);
    $display("test bands done");
    meas.phase = 4'h4;
    meas.pwr = 15'h1234;
    meas.pwr_upd = 1'b1;
    wr(8'h10, 8'h80);
    rd(8'h10, 8'h80);
    cmp1(oen, 1'b1);
    rd(8'h7c, 8'h04);
    rd(8'h7b, 8'h92);
    meas.pwr_upd = 1'b0;
    rd(8'h7b, 8'h12);
    wr(8'h22, 8'h55);
    cmp8(rect, 8'h55);
    ist(1'b1);
    ibyte(8'h46, rb, ak);
    cmp1(ak, 1'b1);
    ist(1'b0);
    $display("test registers done");
    // Fill until refused, then drain to empty.
    n = 0;
    tx_byte = 8'h5a;
    tx_valid = 1'b1;
    for (i = 0; i < 40; i++)
    begin
      ak = tx_ready;
      w(1);
      if (ak)
      begin
        n++;
        tx_byte = 8'h5a ^ n[7:0];
      end
    end
    tx_valid = 1'b0;
    cmp1(tx_ready, 1'b0);
    for (i = 0; i < n; i++)
    begin
      getb(r);
      cmp8(r, 8'h5a ^ i[7:0]);
      cmp1(csb, csa);
    end
    cmp1(tx_ready, 1'b1);
    $display("test stream done");
    // Five terminate causes in turn, released before the next.
    foreach (rs[k])
    begin
      case (k)
        0: pin[3] = 1'b1;
        1: meas.ts = 10'h000;
        4: pin[4] = 1'b1;
        default: wr(8'h30, (k == 2) ? 8'h01 : 8'h02);
      endcase
      getb(r);
      cmp8(r, 8'h02);
      getb(r);
      cmp8(r, rs[k]);
      pin[4:3] = 2'b00;
      meas.ts = 10'h200;
      // Two bit periods, so the idle toggle after a packet sits alone in its window.
      w(80);
    end
    $display("test terminate done");
    for (i = 0; i < 5; i++)
    begin
      pin[2:0] = i[2:0];
      w(10);
      cmp8({5'h00, wl, adn, otg}, me[i]);
    end
    // The adapter now owns the output, so the port must stay silent.
    ist(1'b1);
    ibyte(8'h44, rb, ak);
    cmp1(ak, 1'b1);
    ist(1'b0);
    $display("test modes done");
    end_sim;
  end
endmodule : tb
